// >>> shared/filt_pkg.sv
// Shared constants for the threshold debounce filter block
package filt_pkg;
  // ----------------------------------------------------------------
  // Datapaths and widths
  // ----------------------------------------------------------------
  localparam int NUM_PATHS = 4;
  localparam int SAMPLE_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int LEN_W = 13;
  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] BINARY_FILTER_CONFIG_ADDR = 12'h007;
  localparam logic [11:0] WARN_A_FILTER_ADDR = 12'h008;
  localparam logic [11:0] WARN_B_FILTER_ADDR = 12'h009;
  localparam logic [11:0] WARN_C_FILTER_ADDR = 12'h00a;
  localparam logic [15:0] BINARY_FILTER_CONFIG_RESET = 16'h0096;
  localparam logic [15:0] WARN_FILTER_RESET = 16'h80fa;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 15;
  localparam int UPDOWN_BIT = 14;
  localparam int LENGTH_MSB = 12;
  localparam int LENGTH_LSB = 0;
  localparam logic [15:0] WRITE_MASK = 16'hdfff;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_KHZ = 20000;
  localparam int STEP_US = 20;
  localparam int STEP_CYCLES = (STEP_US * CLOCK_KHZ + 999) / 1000;
endpackage

// >>> src/hysteresis_comparator.sv
// Hysteretic threshold comparator ahead of one debounce filter
`timescale 1ns/100ps
module hysteresis_comparator #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Sample and thresholds
  input wire logic [W-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic [W-1:0] high_i,
  input wire logic [W-1:0] low_i,
  input wire logic enable_i,
  // Result
  output logic compare_o
);
  typedef struct packed {
    logic out;
  } state_t;
  state_t st_r;
  state_t st_nxt;

  if (W < 1) begin : g_chk_w
    $error("Comparator width must be positive");
  end

  always_comb begin
    st_nxt = st_r;
    if (!enable_i) begin
      st_nxt.out = 1'b0;
    end else if (sample_valid_i) begin
      if (sample_i > high_i) begin
        st_nxt.out = 1'b1;
      end else if (sample_i <= low_i) begin
        st_nxt.out = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign compare_o = st_r.out;

  chk_cmp_set_high: assert property (@(posedge clock_i) disable iff (reset_i)
    enable_i && sample_valid_i && sample_i > high_i |=> compare_o)
    else $error("Comparator missed a high crossing");
  chk_cmp_clear_low: assert property (@(posedge clock_i) disable iff (reset_i)
    enable_i && sample_valid_i && sample_i <= low_i && !(sample_i > high_i)
    |=> !compare_o)
    else $error("Comparator missed a low crossing");
endmodule

// >>> src/debounce_filter.sv
// Debounce filter with up/clear and up/down counting
`timescale 1ns/100ps
module debounce_filter #(
  parameter int LEN_W = 13
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Control
  input wire logic step_i,
  input wire logic [LEN_W-1:0] length_i,
  input wire logic updown_i,
  // Data
  input wire logic in_i,
  output logic out_o
);
  typedef struct packed {
    logic out;
    logic [LEN_W-1:0] count;
  } state_t;
  state_t st_r;
  state_t st_nxt;
  logic [LEN_W:0] count_inc;

  if (LEN_W < 1) begin : g_chk_len
    $error("Filter length width must be positive");
  end

  assign count_inc = {1'b0, st_r.count} + {{LEN_W{1'b0}}, 1'b1};

  always_comb begin
    st_nxt = st_r;
    if (length_i == '0) begin
      st_nxt.out = in_i;
      st_nxt.count = '0;
    end else if (step_i) begin
      if (in_i != st_r.out) begin
        if (count_inc >= {1'b0, length_i}) begin
          st_nxt.out = in_i;
          st_nxt.count = '0;
        end else begin
          st_nxt.count = count_inc[LEN_W-1:0];
        end
      end else if (updown_i) begin
        if (st_r.count != '0) begin
          st_nxt.count = st_r.count - 1'b1;
        end
      end else begin
        st_nxt.count = '0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bypass is combinational so a zero length adds no latency
  assign out_o = (length_i == '0) ? in_i : st_r.out;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  chk_flt_bypass: assert property (length_i == '0 |-> out_o == in_i)
    else $error("Bypass output differs from input");
  chk_flt_no_glitch: assert property (
    $changed(st_r.out) && $past(length_i) != '0 |->
      $past(step_i) && $past(count_inc) >= {1'b0, $past(length_i)})
    else $error("Filter output changed before the length elapsed");
  chk_flt_clear_mode: assert property (
    length_i != '0 && step_i && !updown_i && in_i == st_r.out
    |=> st_r.count == '0)
    else $error("Up/clear mode did not restart the count");
  chk_flt_down_mode: assert property (
    length_i != '0 && step_i && updown_i && in_i == st_r.out &&
    st_r.count != '0 |=> st_r.count == $past(st_r.count) - 1'b1)
    else $error("Up/down mode did not lower the count");
endmodule

// >>> src/threshold_debounce_filters.sv
// Binary and warning comparator datapaths with debounce filters
`timescale 1ns/100ps
// Overview of operation
// - Binary path disabled forces its comparator output low.
// - Binary path enable bit reads zero after reset.
// - Mode bit set gives up/down counting, clear gives up/clear.
// - A 13-bit length field counts filter time in 20 us steps.
// - In up/clear mode, pulses shorter than the programmed length leave the output unchanged.
// - Zero length bypasses the filter with no added latency.
// - Three warning paths reset enabled, up/clear, length 0xfa.
// - Binary configuration resets disabled, up/clear, length 0x96.
// - Comparator sets above high threshold, clears at or below low.
// - A rising filtered warning output raises an event pulse.
module threshold_debounce_filters
  import filt_pkg::*;
#(
  parameter int STEP_TICKS = filt_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // Register port
  input wire logic [filt_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [filt_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  output logic [filt_pkg::DATA_W-1:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // ADC samples and per-path thresholds
  input wire logic [filt_pkg::SAMPLE_W-1:0] SAMPLE_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic [filt_pkg::NUM_PATHS-1:0][filt_pkg::SAMPLE_W-1:0]
    THRESH_HIGH_I,
  input wire logic [filt_pkg::NUM_PATHS-1:0][filt_pkg::SAMPLE_W-1:0]
    THRESH_LOW_I,
  // Filtered outputs
  output logic DIGITAL_STATE_OUTPUT_O,
  output logic WARNING_A_COMPARATOR_O,
  output logic WARNING_B_COMPARATOR_O,
  output logic WARNING_C_COMPARATOR_O,
  // Warning rise events
  output logic [filt_pkg::NUM_PATHS-2:0] WARNING_EVENT_O
);
  import filt_pkg::*;

  // ----------------------------------------------------------------
  // Local types and constants
  // ----------------------------------------------------------------
  localparam int TW = (STEP_TICKS > 1) ? $clog2(STEP_TICKS) : 1;
  localparam int NW = NUM_PATHS - 1;
  localparam int TICK_GAP = STEP_TICKS;
  localparam logic [TW-1:0] TICK_LAST = TW'(STEP_TICKS - 1);

  typedef struct packed {
    logic [NUM_PATHS-1:0][DATA_W-1:0] cfg;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [NW-1:0] warn_prev;
    logic [NW-1:0] warn_event;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_PATHS-1:0] path_enable;
  logic [NUM_PATHS-1:0] path_updown;
  logic [NUM_PATHS-1:0][LEN_W-1:0] path_length;
  logic [NUM_PATHS-1:0] cmp_out;
  logic [NUM_PATHS-1:0] filt_out;
  logic addr_hit;
  logic [1:0] addr_idx;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (STEP_TICKS < 1) begin : g_chk_step
    $error("STEP_TICKS must be at least one cycle");
  end
  if (NUM_PATHS != 4) begin : g_chk_paths
    $error("Register map serves exactly four datapaths");
  end
  // Step period check unrolls the gap, so keep it within range
  if (STEP_TICKS > 1000) begin : g_chk_step_max
    $error("STEP_TICKS above the checkable range of 1000");
  end
  if (LENGTH_MSB - LENGTH_LSB + 1 != LEN_W) begin : g_chk_len
    $error("Length field does not match the filter counter");
  end
  if (ENABLE_BIT >= DATA_W || UPDOWN_BIT >= DATA_W) begin : g_chk_bits
    $error("Control bits lie outside the register word");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    addr_hit = 1'b1;
    addr_idx = 2'h0;
    unique case (REG_ADDR_I)
      BINARY_FILTER_CONFIG_ADDR: addr_idx = 2'h0;
      WARN_A_FILTER_ADDR: addr_idx = 2'h1;
      WARN_B_FILTER_ADDR: addr_idx = 2'h2;
      WARN_C_FILTER_ADDR: addr_idx = 2'h3;
      default: addr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Reserved bit is never stored, so it always reads zero
    if (REG_WRITE_I && addr_hit) begin
      st_nxt.cfg[addr_idx] = REG_WDATA_I & WRITE_MASK;
    end
    // One step strobe per 20 us shared by all filters
    if (st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
      st_nxt.tick = 1'b0;
    end
    st_nxt.rvalid = REG_READ_I;
    if (REG_READ_I) begin
      st_nxt.rdata = addr_hit ? st_r.cfg[addr_idx] : '0;
    end
    // Event is one cycle behind the rise of the filtered output
    st_nxt.warn_prev = filt_out[NUM_PATHS-1:1];
    st_nxt.warn_event = filt_out[NUM_PATHS-1:1] & ~st_r.warn_prev;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st_r <= '0;
      st_r.cfg[0] <= BINARY_FILTER_CONFIG_RESET;
      st_r.cfg[1] <= WARN_FILTER_RESET;
      st_r.cfg[2] <= WARN_FILTER_RESET;
      st_r.cfg[3] <= WARN_FILTER_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Datapaths
  // ----------------------------------------------------------------
  // One shared step strobe keeps all four filters in phase
  for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
    assign path_enable[p] = st_r.cfg[p][ENABLE_BIT];
    assign path_updown[p] = st_r.cfg[p][UPDOWN_BIT];
    assign path_length[p] = st_r.cfg[p][LENGTH_MSB:LENGTH_LSB];

    hysteresis_comparator #(
      .W(SAMPLE_W)
    ) u_cmp (
      .clock_i(CLOCK_I),
      .reset_i(RESET_I),
      .sample_i(SAMPLE_I),
      .sample_valid_i(SAMPLE_VALID_I),
      .high_i(THRESH_HIGH_I[p]),
      .low_i(THRESH_LOW_I[p]),
      .enable_i(path_enable[p]),
      .compare_o(cmp_out[p])
    );

    debounce_filter #(
      .LEN_W(LEN_W)
    ) u_flt (
      .clock_i(CLOCK_I),
      .reset_i(RESET_I),
      .step_i(st_r.tick),
      .length_i(path_length[p]),
      .updown_i(path_updown[p]),
      .in_i(cmp_out[p]),
      .out_o(filt_out[p])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DIGITAL_STATE_OUTPUT_O = filt_out[0];
  assign WARNING_A_COMPARATOR_O = filt_out[1];
  assign WARNING_B_COMPARATOR_O = filt_out[2];
  assign WARNING_C_COMPARATOR_O = filt_out[3];
  assign WARNING_EVENT_O = st_r.warn_event;
  assign REG_RDATA_O = st_r.rdata;
  assign REG_RVALID_O = st_r.rvalid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  chk_bin_forced_low: assert property (
    !path_enable[0] && $past(!path_enable[0]) |-> !cmp_out[0])
    else $error("Disabled binary comparator is not low");

  chk_bin_reset_off: assert property (
    $past(RESET_I) |-> !path_enable[0] && REG_RDATA_O == '0)
    else $error("Binary enable not clear after reset");

  chk_bin_reset_cfg: assert property (
    $past(RESET_I) |-> st_r.cfg[0] == BINARY_FILTER_CONFIG_RESET)
    else $error("Binary configuration reset value wrong");

  chk_warn_reset_cfg: assert property (
    $past(RESET_I) |-> st_r.cfg[1] == WARN_FILTER_RESET &&
      st_r.cfg[2] == WARN_FILTER_RESET &&
      st_r.cfg[3] == WARN_FILTER_RESET)
    else $error("Warning configuration reset value wrong");

  chk_step_period: assert property (
    st_r.tick |-> ##[TICK_GAP:TICK_GAP] st_r.tick)
    else $error("Step strobe period wrong");

  chk_mode_write: assert property (
    REG_WRITE_I && addr_hit |=>
      path_updown[$past(addr_idx)] == $past(REG_WDATA_I[UPDOWN_BIT]) &&
      (st_r.cfg[$past(addr_idx)] & ~WRITE_MASK) == '0)
    else $error("Mode bit write not taken");

  chk_read_back: assert property (
    REG_READ_I && !addr_hit |=> REG_RVALID_O && REG_RDATA_O == '0)
    else $error("Unmapped read did not return zero");

  chk_rvalid_pulse: assert property (
    !$past(RESET_I) |-> REG_RVALID_O == $past(REG_READ_I))
    else $error("Read answer strobe not one cycle after read");

  chk_read_data: assert property (
    REG_READ_I && addr_hit |=> REG_RDATA_O == $past(st_r.cfg[addr_idx]))
    else $error("Read data differs from the addressed register");

  chk_rdata_hold: assert property (
    !REG_READ_I |=> $stable(REG_RDATA_O))
    else $error("Read data changed without a read");

  chk_cfg_hold: assert property (
    !(REG_WRITE_I && addr_hit) |=> $stable(st_r.cfg))
    else $error("Configuration changed without a mapped write");

  chk_length_write: assert property (
    REG_WRITE_I && addr_hit |=>
      path_length[$past(addr_idx)] ==
        $past(REG_WDATA_I[LENGTH_MSB:LENGTH_LSB]))
    else $error("Length field write not taken");

  chk_enable_write: assert property (
    REG_WRITE_I && addr_hit |=>
      path_enable[$past(addr_idx)] == $past(REG_WDATA_I[ENABLE_BIT]))
    else $error("Enable bit write not taken");

  // ----------------------------------------------------------------
  // Datapath checks
  // ----------------------------------------------------------------

  chk_warn_event: assert property (
    $rose(filt_out[1]) |=> WARNING_EVENT_O[0])
    else $error("Warning A rise gave no event");

  chk_event_cause: assert property (
    WARNING_EVENT_O[1] |-> $past(filt_out[2]) && !$past(filt_out[2], 2))
    else $error("Warning B event without a rise");

  chk_bypass_follow: assert property (
    path_length[0] == '0 |-> DIGITAL_STATE_OUTPUT_O == cmp_out[0])
    else $error("Binary bypass adds latency");

  chk_hold_short: assert property (
    path_length[1] != '0 && $stable(path_length[1]) && !st_r.tick
    |=> $stable(WARNING_A_COMPARATOR_O))
    else $error("Warning A output moved between steps");

  chk_bin_cmp_rise: assert property (
    path_enable[0] && SAMPLE_VALID_I && SAMPLE_I > THRESH_HIGH_I[0]
    |=> cmp_out[0])
    else $error("Binary comparator missed a high crossing");

  chk_flip_on_step: assert property (
    path_length[1] != '0 && $past(path_length[1]) != '0 &&
      $changed(filt_out[1]) |-> $past(st_r.tick))
    else $error("Warning A output flipped off a step");

  chk_event_single: assert property (
    (WARNING_EVENT_O & $past(WARNING_EVENT_O)) == '0)
    else $error("Warning event lasted more than one cycle");

  cov_bin_rise: cover property ($rose(DIGITAL_STATE_OUTPUT_O));
  cov_warn_event: cover property (|WARNING_EVENT_O);
  cov_updown_on: cover property (REG_WRITE_I && addr_hit &&
    REG_WDATA_I[UPDOWN_BIT]);
  cov_bypass: cover property (path_length[0] == '0 && path_enable[0]);
  cov_warn_b_rise: cover property ($rose(WARNING_B_COMPARATOR_O));
endmodule

// >>> verification/host_model.sv
// Host side of the register port, issuing writes and reads
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clock_i,
  // Register port
  output logic [filt_pkg::ADDR_W-1:0] addr_o,
  output logic [filt_pkg::DATA_W-1:0] wdata_o,
  output logic write_o,
  output logic read_o,
  input wire logic [filt_pkg::DATA_W-1:0] rdata_i,
  input wire logic rvalid_i
);
  import filt_pkg::*;

  initial begin
    addr_o = '0;
    wdata_o = '0;
    write_o = 1'b0;
    read_o = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clock_i);
    write_o <= 1'b0;
    // Released lines show no stale value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    d = 'x;
    @(posedge clock_i);
    addr_o <= a;
    read_o <= 1'b1;
    @(posedge clock_i);
    read_o <= 1'b0;
    addr_o <= ~a;
    for (n = 0; n < 4; n++) begin
      @(posedge clock_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
    end
  endtask
endmodule

// >>> verification/test_threshold_debounce_filters.sv
// Self-checking bench for the debounce filter block
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module test_threshold_debounce_filters;
  import filt_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  logic wr_s;
  logic rd_s;
  logic rvalid;
  logic [SAMPLE_W-1:0] smp;
  logic vld;
  logic [NUM_PATHS-1:0][SAMPLE_W-1:0] thr_hi;
  logic [NUM_PATHS-1:0][SAMPLE_W-1:0] thr_lo;
  logic dout;
  logic wa;
  logic wb;
  logic wc;
  logic [NUM_PATHS-2:0] ev;
  int err_count = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  int evb_cnt = 0;
  int ev0;

  // Small step count keeps the run short: one step is 4 cycles
  threshold_debounce_filters #(.STEP_TICKS(4)) DUT (
    .CLOCK_I(clk), .RESET_I(rst),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WRITE_I(wr_s), .REG_READ_I(rd_s),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .SAMPLE_I(smp), .SAMPLE_VALID_I(vld),
    .THRESH_HIGH_I(thr_hi), .THRESH_LOW_I(thr_lo),
    .DIGITAL_STATE_OUTPUT_O(dout), .WARNING_A_COMPARATOR_O(wa),
    .WARNING_B_COMPARATOR_O(wb), .WARNING_C_COMPARATOR_O(wc),
    .WARNING_EVENT_O(ev)
  );

  host_model host (
    .clock_i(clk), .addr_o(addr), .wdata_o(wdata), .write_o(wr_s),
    .read_o(rd_s), .rdata_i(rdata), .rvalid_i(rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ev[0] === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
    if (ev[1] === 1'b1) begin
      evb_cnt <= evb_cnt + 1;
    end
  end

  // Sample held for n cycles
  task automatic hold(input logic [SAMPLE_W-1:0] v, input int n);
    @(posedge clk);
    smp <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  task automatic t_reset();
    host.rd(BINARY_FILTER_CONFIG_ADDR, rv);
    `CHK(rv, 16'h0096);
    host.rd(WARN_A_FILTER_ADDR, rv);
    `CHK(rv, 16'h80fa);
    host.rd(WARN_B_FILTER_ADDR, rv);
    `CHK(rv, 16'h80fa);
    host.rd(WARN_C_FILTER_ADDR, rv);
    `CHK(rv, 16'h80fa);
    host.rd(12'h00b, rv);
    `CHK(rv, 16'h0000);
    `CHK({dout, wa, wb, wc, ev}, 7'h00);
  endtask

  task automatic t_mask();
    host.wr(BINARY_FILTER_CONFIG_ADDR, 16'hffff);
    host.rd(BINARY_FILTER_CONFIG_ADDR, rv);
    `CHK(rv, 16'hdfff);
    host.wr(BINARY_FILTER_CONFIG_ADDR, 16'h0000);
  endtask

  task automatic t_bin();
    hold(8'hc0, 8);
    `CHK(dout, 1'b0);
    host.wr(BINARY_FILTER_CONFIG_ADDR, 16'h8000);
    hold(8'hc0, 1);
    @(posedge clk);
    #1;
    `CHK(dout, 1'b1);
    hold(8'h60, 2);
    #1;
    `CHK(dout, 1'b1);
    hold(8'h40, 1);
    @(posedge clk);
    #1;
    `CHK(dout, 1'b0);
  endtask

  // Glitch pattern: two mismatching steps, one match, two mismatching
  task automatic pattern();
    hold(8'h20, 20);
    hold(8'hc0, 8);
    hold(8'h20, 4);
    hold(8'hc0, 8);
    hold(8'h20, 4);
    #1;
  endtask

  task automatic t_filter();
    host.wr(WARN_A_FILTER_ADDR, 16'h8003);
    pattern();
    `CHK(wa, 1'b0);
    hold(8'hc0, 12);
    hold(8'h20, 4);
    #1;
    `CHK(wa, 1'b1);
    host.wr(WARN_A_FILTER_ADDR, 16'hc003);
    hold(8'h20, 24);
    `CHK(wa, 1'b0);
    ev0 = ev_cnt;
    pattern();
    `CHK(wa, 1'b1);
    `CHK(ev_cnt, ev0 + 1);
    `CHK({wb, wc, ev[2:1]}, 4'h0);
  endtask

  // Warning B alone with a one-step length; A and C must not react
  task automatic t_warn_b();
    host.wr(WARN_B_FILTER_ADDR, 16'h8001);
    thr_hi[2] <= 8'h80;
    hold(8'hc0, 12);
    #1;
    `CHK({wa, wb, wc}, 3'h6);
    `CHK(evb_cnt, 1);
    `CHK(ev_cnt, ev0 + 1);
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    smp = 8'h20;
    vld = 1'b1;
    // Paths B and C kept quiet: high threshold cannot be exceeded
    thr_hi = {8'hff, 8'hff, 8'h80, 8'h80};
    thr_lo = {8'h40, 8'h40, 8'h40, 8'h40};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mask();
    t_bin();
    t_filter();
    t_warn_b();
    report_and_stop();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
